// *** include/sample_queue_pkg.sv ***
`default_nettype none
package sample_queue_pkg;

   // =====================================================================
   // register map (printed indices, byte address is four times the index)
   // =====================================================================
   localparam logic [7:0]  CTRL_INDEX         = 8'h3a;
   localparam logic [7:0]  STATUS_INDEX       = 8'h3b;
   localparam logic [7:0]  DATA_INDEX         = 8'h3c;
   localparam int          ADDR_BITS          = 10;

   // =====================================================================
   // control fields
   // =====================================================================
   localparam int          WRITE_ERR_EN_BIT   = 14;
   localparam int          READ_ERR_EN_BIT    = 13;
   localparam int          UPPER_EN_BIT       = 12;
   localparam int          LOWER_EN_BIT       = 11;
   localparam int          OVERRUN_EN_BIT     = 10;
   localparam int          WATERMARK_EN_BIT   = 9;
   localparam int          EMPTY_EN_BIT       = 8;
   localparam int          MODE_LSB           = 16;
   localparam int          WM_LSB             = 0;
   localparam int          WM_WIDTH           = 8;
   localparam logic [23:0] CTRL_RESET         = 24'h040200;
   localparam logic [23:0] CTRL_WRITE_MASK    = 24'h0fffff;

   // =====================================================================
   // status fields
   // =====================================================================
   localparam int          CTRL_ERR_BIT       = 7;
   localparam int          WRITE_ERR_BIT      = 6;
   localparam int          READ_ERR_BIT       = 5;
   localparam int          UPPER_FLAG_BIT     = 4;
   localparam int          LOWER_FLAG_BIT     = 3;
   localparam int          OVERRUN_FLAG_BIT   = 2;
   localparam int          WATERMARK_FLAG_BIT = 1;
   localparam int          EMPTY_FLAG_BIT     = 0;
   localparam logic [7:0]  STATUS_RESET       = 8'h01;

   // =====================================================================
   // queue geometry and modes
   // =====================================================================
   localparam int          FIFO_DEPTH         = 256;
   localparam int          SAMPLE_WIDTH       = 24;

   typedef enum logic [1:0]
   {
      MODE_DISABLED  = 2'h0,
      MODE_WATERMARK = 2'h1,
      MODE_STREAM_A  = 2'h2,
      MODE_STREAM_B  = 2'h3
   } fifo_mode_type;

   typedef enum logic [1:0]
   {
      BUS_IDLE = 2'h0,
      BUS_WAIT = 2'h1,
      BUS_DONE = 2'h3
   } bus_state_type;

endpackage : sample_queue_pkg
`default_nettype wire

// *** rtl/sample_skid_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none
module sample_skid_buffer
#(
   parameter int WIDTH = 24
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             out_valid,
   input  wire logic             out_ready,
   output var  logic [WIDTH-1:0] out_data
);

   logic [WIDTH-1:0] slot0_q;
   logic [WIDTH-1:0] slot1_q;
   logic [1:0]       cnt_q;
   logic [1:0]       cnt_d;
   logic             push;
   logic             pop;

   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_valid = (cnt_q != 2'h0);
   assign out_data  = slot0_q;

   always_comb
   begin
      cnt_d = cnt_q;
      if (push && !pop)
         cnt_d = cnt_q + 2'h1;
      else if (pop && !push)
         cnt_d = cnt_q - 2'h1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q    <= 2'h0;
         in_ready <= 1'b1;
      end
      else
      begin
         cnt_q    <= cnt_d;
         in_ready <= (cnt_d != 2'h2);
      end
   end

   // =====================================================================
   // slot storage, slot0 is always the oldest word
   // =====================================================================
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         slot0_q <= '0;
         slot1_q <= '0;
      end
      else
      begin
         if (pop)
         begin
            slot0_q <= (push && cnt_q == 2'h1) ? in_data : slot1_q;
            if (push && cnt_q == 2'h2)
               slot1_q <= in_data;
         end
         else if (push)
         begin
            if (cnt_q == 2'h0)
               slot0_q <= in_data;
            else
               slot1_q <= in_data;
         end
      end
   end

endmodule : sample_skid_buffer
`default_nettype wire

// *** rtl/adc_sample_fifo_irq_watermark_ctrl.sv ***
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module adc_sample_fifo_irq_watermark_ctrl
#(
   parameter int DEPTH = sample_queue_pkg::FIFO_DEPTH,
   parameter int SW    = sample_queue_pkg::SAMPLE_WIDTH
)
(
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output var  logic          hreadyout,
   output var  logic [31:0]   hrdata,
   output var  logic          hresp,
   input  wire logic          sample_valid,
   output var  logic          sample_ready,
   input  wire logic [SW-1:0] sample_data,
   input  wire logic          upper_limit_flag,
   input  wire logic          lower_limit_flag,
   output var  logic          fifo_irq
);
   import sample_queue_pkg::*;

   localparam int CW = $clog2(DEPTH) + 1;
   localparam int PW = $clog2(DEPTH);
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [ADDR_BITS-1:0] CTRL_ADDR   = {CTRL_INDEX, 2'b00};
   localparam logic [ADDR_BITS-1:0] STATUS_ADDR = {STATUS_INDEX, 2'b00};
   localparam logic [ADDR_BITS-1:0] DATA_ADDR   = {DATA_INDEX, 2'b00};

   // =====================================================================
   // decoding
   // =====================================================================
   function automatic logic [CW-1:0] wm_level(input logic [WM_WIDTH-1:0] wm);
      wm_level = (wm == '0) ? DEPTH_C : CW'(wm);
   endfunction : wm_level

   function automatic logic fifo_on(input logic [1:0] mode);
      fifo_on = (mode != MODE_DISABLED);
   endfunction : fifo_on

   bus_state_type           state_q;
   bus_state_type           state_d;
   logic [ADDR_BITS-1:0]    addr_q;
   logic                    write_q;
   logic [23:0]             ctrl_q;
   logic [7:0]              status_q;
   logic [7:0]              status_d;
   logic [SW-1:0]           mem [DEPTH];
   logic [PW-1:0]           wr_ptr_q;
   logic [PW-1:0]           rd_ptr_q;
   logic [CW-1:0]           count_q;
   logic [CW-1:0]           count_d;
   logic                    wm_lock_q;
   logic [SW-1:0]           last_sample_q;
   logic                    take;
   logic                    access;
   logic                    drain_valid;
   logic                    drain_ready;
   logic [SW-1:0]           drain_data;
   logic                    drain_fire;
   logic [1:0]              mode;
   logic [CW-1:0]           level;
   logic                    data_rd;
   logic                    pop;
   logic                    rd_empty;
   logic                    stream_full;
   logic                    wm_discard;
   logic                    push;
   logic                    refused;
   logic                    status_rd;

   assign mode    = ctrl_q[MODE_LSB +: 2];
   assign level   = wm_level(ctrl_q[WM_LSB +: WM_WIDTH]);
   assign take    = hsel && hready && htrans[1];
   assign access  = (state_q == BUS_WAIT);

   // =====================================================================
   // AHB-Lite slave: one wait state per transfer
   // =====================================================================
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         BUS_IDLE: state_d = take ? BUS_WAIT : BUS_IDLE;
         BUS_WAIT: state_d = BUS_DONE;
         BUS_DONE: state_d = take ? BUS_WAIT : BUS_IDLE;
         default:  state_d = BUS_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_q   <= BUS_IDLE;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         addr_q    <= '0;
         write_q   <= 1'b0;
      end
      else
      begin
         state_q   <= state_d;
         hreadyout <= (state_d != BUS_WAIT);
         hresp     <= 1'b0;
         if (take && state_q != BUS_WAIT)
         begin
            addr_q  <= haddr[ADDR_BITS-1:0];
            write_q <= hwrite;
         end
      end
   end

   // reserved bits above the append bits are not stored
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ctrl_q <= CTRL_RESET;
      else if (access && write_q && addr_q == CTRL_ADDR)
         ctrl_q <= hwdata[23:0] & CTRL_WRITE_MASK;
   end

   assign data_rd   = access && !write_q && addr_q == DATA_ADDR;
   assign status_rd = access && !write_q && addr_q == STATUS_ADDR;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= '0;
      else if (access && !write_q)
      begin
         if (addr_q == CTRL_ADDR)
            hrdata <= {8'h00, ctrl_q};
         else if (addr_q == STATUS_ADDR)
            hrdata <= {24'h000000, status_q};
         else if (data_rd && !fifo_on(mode))
            hrdata <= 32'(last_sample_q);
         else if (data_rd && count_q != '0)
            hrdata <= 32'(mem[rd_ptr_q]);
         else
            hrdata <= '0;
      end
   end

   // =====================================================================
   // input buffer, drained except while a register access is served
   // =====================================================================
   sample_skid_buffer
   #(
      .WIDTH (SW)
   )
   u_in_buf
   (
      .clk       (hclk),
      .rst_n     (hresetn),
      .in_valid  (sample_valid),
      .in_ready  (sample_ready),
      .in_data   (sample_data),
      .out_valid (drain_valid),
      .out_ready (drain_ready),
      .out_data  (drain_data)
   );

   assign drain_ready = !access;
   assign drain_fire  = drain_valid && drain_ready;
   assign refused     = sample_valid && !sample_ready;

   // =====================================================================
   // queue events
   // =====================================================================
   assign pop         = data_rd && fifo_on(mode) && count_q != '0;
   assign rd_empty    = data_rd && fifo_on(mode) && count_q == '0;
   assign stream_full = drain_fire && mode[1] && count_q == DEPTH_C;
   assign wm_discard  = drain_fire && mode == MODE_WATERMARK
                        && (wm_lock_q || count_q == DEPTH_C);
   assign push        = drain_fire && fifo_on(mode) && !wm_discard;

   always_comb
   begin
      count_d = count_q;
      if (!fifo_on(mode))
         count_d = '0;
      else if (push && !stream_full)
         count_d = count_q + CW'(1);
      else if (pop)
         count_d = count_q - CW'(1);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         count_q  <= '0;
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end
      else if (!fifo_on(mode))
      begin
         count_q  <= '0;
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end
      else
      begin
         count_q <= count_d;
         if (push)
            wr_ptr_q <= wr_ptr_q + PW'(1);
         if (pop || stream_full)
            rd_ptr_q <= rd_ptr_q + PW'(1);
      end
   end

   always_ff @(posedge hclk)
   begin
      if (push)
         mem[wr_ptr_q] <= drain_data;
   end

   // watermark mode treats the queue as full from level reached to empty
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         wm_lock_q <= 1'b0;
      else if (mode != MODE_WATERMARK || count_d == '0)
         wm_lock_q <= 1'b0;
      else if (count_d >= level)
         wm_lock_q <= 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         last_sample_q <= '0;
      else if (drain_fire && !fifo_on(mode))
         last_sample_q <= drain_data;
   end

   // =====================================================================
   // status flags, a new event wins over a clear in the same cycle
   // =====================================================================
   always_comb
   begin
      status_d = status_q;
      if (status_rd)
      begin
         status_d[OVERRUN_FLAG_BIT] = 1'b0;
         status_d[READ_ERR_BIT]     = 1'b0;
      end
      if (count_d == '0)
         status_d[WRITE_ERR_BIT] = 1'b0;
      if (fifo_on(mode))
      begin
         if (stream_full || wm_discard)
            status_d[OVERRUN_FLAG_BIT] = 1'b1;
         if (wm_discard || refused)
            status_d[WRITE_ERR_BIT] = 1'b1;
         if (rd_empty)
            status_d[READ_ERR_BIT] = 1'b1;
      end
      else
      begin
         status_d[OVERRUN_FLAG_BIT] = 1'b0;
         status_d[READ_ERR_BIT]     = 1'b0;
         status_d[WRITE_ERR_BIT]    = 1'b0;
      end
      status_d[UPPER_FLAG_BIT]     = fifo_on(mode) && upper_limit_flag;
      status_d[LOWER_FLAG_BIT]     = fifo_on(mode) && lower_limit_flag;
      status_d[WATERMARK_FLAG_BIT] = fifo_on(mode) && count_d >= level;
      status_d[EMPTY_FLAG_BIT]     = (count_d == '0);
      status_d[CTRL_ERR_BIT]       = status_d[WRITE_ERR_BIT] || status_d[READ_ERR_BIT]
                                     || status_d[OVERRUN_FLAG_BIT];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         status_q <= STATUS_RESET;
      else
         status_q <= status_d;
   end

   // =====================================================================
   // interrupt sources, enable bit i of the group gates source flag i
   // =====================================================================
   localparam int NSRC = WRITE_ERR_EN_BIT - EMPTY_EN_BIT + 1;

   logic [NSRC-1:0] src_flag;
   logic [NSRC-1:0] src_en;
   logic [NSRC-1:0] src_hit;

   // flag order follows the enable bits, write error on top, empty at bit 0
   assign src_en   = ctrl_q[WRITE_ERR_EN_BIT:EMPTY_EN_BIT];
   assign src_flag = {status_d[WRITE_ERR_BIT],
                      status_d[READ_ERR_BIT],
                      status_d[UPPER_FLAG_BIT],
                      status_d[LOWER_FLAG_BIT],
                      status_d[OVERRUN_FLAG_BIT],
                      status_d[WATERMARK_FLAG_BIT],
                      status_d[EMPTY_FLAG_BIT]};

   for (genvar i = 0; i < NSRC; i++)
   begin : g_src
      assign src_hit[i] = src_en[i] && src_flag[i];
   end

   // =====================================================================
   // interrupt, taken from next flag values so it moves on the flag's edge
   // =====================================================================
   // next flags are used so that the pin and the flag change on one edge
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         fifo_irq <= 1'b0;
      else
         fifo_irq <= |src_hit;
   end

endmodule : adc_sample_fifo_irq_watermark_ctrl
`default_nettype wire

// *** tb/sample_queue_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module sample_queue_sva
#(
   parameter int DEPTH = 256,
   parameter int SW    = 24
)
(
   input wire logic          hclk,
   input wire logic          hresetn,
   input wire logic          hsel,
   input wire logic [31:0]   haddr,
   input wire logic [1:0]    htrans,
   input wire logic          hwrite,
   input wire logic [2:0]    hsize,
   input wire logic [31:0]   hwdata,
   input wire logic          hready,
   input wire logic          hreadyout,
   input wire logic [31:0]   hrdata,
   input wire logic          hresp,
   input wire logic          sample_valid,
   input wire logic          sample_ready,
   input wire logic [SW-1:0] sample_data,
   input wire logic          upper_limit_flag,
   input wire logic          lower_limit_flag,
   input wire logic          fifo_irq
);
   import sample_queue_pkg::*;
   // =========================================
   // shadow of the control word
   // =========================================
   logic        take;
   logic        pend_q;
   logic [23:0] ctrl_q;
   assign take = hsel && hready && htrans[1] && hreadyout;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pend_q <= 1'b0;
         ctrl_q <= CTRL_RESET;
      end
      else
      begin
         pend_q <= take && hwrite && (haddr[9:0] == {CTRL_INDEX, 2'b00});
         if (pend_q)
            ctrl_q <= hwdata[23:0] & CTRL_WRITE_MASK;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // =========================================
   // properties
   // =========================================
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   wait_once_a: assert property (take |=> !hreadyout ##1 hreadyout)
      else $error("wait cycle count wrong");
   wait_cause_a: assert property ($fell(hreadyout) |-> $past(take))
      else $error("wait without transfer");
   rdata_hold_a: assert property (!$stable(hrdata) |-> !$past(hreadyout))
      else $error("read data moved outside a transfer");
   irq_quiet_a: assert property
      (ctrl_q[14:8] == 7'h00 && $past(ctrl_q) == ctrl_q |-> !fifo_irq)
      else $error("interrupt with all enables off");
   irq_upper_a: assert property
      (ctrl_q[12] && $past(ctrl_q[12]) && upper_limit_flag && $past(upper_limit_flag)
       && ctrl_q[17:16] != 2'b00 && $past(ctrl_q[17:16]) != 2'b00
       |-> ##[0:1] fifo_irq)
      else $error("upper limit interrupt missing");
   irq_lower_a: assert property
      (ctrl_q[11] && $past(ctrl_q[11]) && lower_limit_flag && $past(lower_limit_flag)
       && ctrl_q[17:16] != 2'b00 && $past(ctrl_q[17:16]) != 2'b00
       |-> ##[0:1] fifo_irq)
      else $error("lower limit interrupt missing");
   irq_cause_a: assert property ($rose(fifo_irq) |-> $past(ctrl_q[14:8]) != 7'h00)
      else $error("interrupt rose with no enable");
   cover property (take && hwrite);
   cover property ($rose(fifo_irq));
   cover property ($fell(fifo_irq));
endmodule : sample_queue_sva
bind adc_sample_fifo_irq_watermark_ctrl sample_queue_sva #(.DEPTH(DEPTH), .SW(SW)) chk_i
(
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
   .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
   .upper_limit_flag(upper_limit_flag), .lower_limit_flag(lower_limit_flag),
   .fifo_irq(fifo_irq)
);
`default_nettype wire

// *** tb/ahb_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ahb_host_model
(
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output var  logic        hsel,
   output var  logic [31:0] haddr,
   output var  logic [1:0]  htrans,
   output var  logic        hwrite,
   output var  logic [2:0]  hsize,
   output var  logic [31:0] hwdata
);
   // =========================================
   // single word transfers, one at a time
   // =========================================
   initial
   begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge hclk); while (!hready);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      haddr  <= ~a;
      hwdata <= d & 32'hffff7fff;
      do @(posedge hclk); while (!hready);
      r = hrdata;
      hwdata <= ~(d & 32'hffff7fff);
   endtask : xfer
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [31:0] a, output logic [31:0] r);
      xfer(1'b0, a, 32'h0, r);
   endtask : rd
endmodule : ahb_host_model
`default_nettype wire

// *** tb/adc_sample_fifo_irq_watermark_ctrl_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_sample_fifo_irq_watermark_ctrl_bench;
   import sample_queue_pkg::*;
   localparam int          D     = 8;
   localparam logic [31:0] ACTRL = {22'h0, CTRL_INDEX, 2'b00};
   localparam logic [31:0] ASTAT = {22'h0, STATUS_INDEX, 2'b00};
   localparam logic [31:0] ADATA = {22'h0, DATA_INDEX, 2'b00};
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, fifo_irq;
   logic        sample_valid, sample_ready, upper_limit_flag, lower_limit_flag;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [23:0] sample_data;
   logic [23:0] q[$];
   int          fails, cmp_count, cyc, b, m;
   integer      seed;
   ahb_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   adc_sample_fifo_irq_watermark_ctrl #(.DEPTH(D)) dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .sample_valid(sample_valid), .sample_ready(sample_ready),
      .sample_data(sample_data), .upper_limit_flag(upper_limit_flag),
      .lower_limit_flag(lower_limit_flag), .fifo_irq(fifo_irq));
   // =========================================
   // helpers and reference queue
   // =========================================
   task automatic chk(input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task automatic push(input int n, input int mode, input int nwm);
      logic [23:0] d;
      for (int k = 0; k < n; k++)
      begin
         d = $random(seed);
         sample_data  <= d;
         sample_valid <= 1'b1;
         do @(posedge hclk); while (!sample_ready);
         sample_valid <= 1'b0;
         sample_data  <= ~d;
         if (mode >= 2 || q.size() < nwm)
            q.push_back(d);
         if (q.size() > D)
            void'(q.pop_front());
         @(posedge hclk);
      end
      repeat (6) @(posedge hclk);
   endtask : push
   task automatic drain();
      while (q.size() > 0)
      begin
         host.rd(ADATA, v);
         chk(v, {8'h00, q.pop_front()});
      end
   endtask : drain
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         end_sim();
      end
   end
   // =========================================
   // scenarios
   // =========================================
   initial
   begin
      seed = 32'hc9a89063;
      hresetn = 1'b0;
      sample_valid = 1'b0;
      sample_data = 24'h0;
      upper_limit_flag = 1'b0;
      lower_limit_flag = 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      host.rd(ACTRL, v);
      chk(v, 32'h00040200);
      host.rd(ASTAT, v);
      chk(v, 32'h01);
      host.rd(32'h3fc, v);
      chk(v, 32'h0);
      chk(32'(fifo_irq), 32'h0);
      $display("test reset done");
      for (b = 8; b < 15; b++)
      begin
         upper_limit_flag <= (($random(seed) & 1) != 0) || (b == 12);
         lower_limit_flag <= (($random(seed) & 1) != 0) || (b == 11);
         host.wr(ACTRL, (32'h2 << MODE_LSB) | (32'h1 << b));
         repeat (3) @(posedge hclk);
         chk(32'(fifo_irq), 32'((b == 8) || (b == 12 && upper_limit_flag)
            || (b == 11 && lower_limit_flag)));
      end
      upper_limit_flag <= 1'b0;
      lower_limit_flag <= 1'b0;
      host.wr(ACTRL, 32'h0);
      repeat (3) @(posedge hclk);
      chk(32'(fifo_irq), 32'h0);
      $display("test enables done");
      for (m = 2; m < 4; m++)
      begin
         host.wr(ACTRL, (m << 16) | 32'h0600);
         push(D + 2, m, 0);
         chk(32'(fifo_irq), 32'h1);
         host.rd(ASTAT, v);
         chk(v, 32'h86);
         drain();
         host.rd(ASTAT, v);
         chk(v, 32'h01);
         chk(32'(fifo_irq), 32'h0);
      end
      $display("test streaming done");
      host.wr(ACTRL, 32'h00014003);
      push(5, 1, 3);
      chk(32'(fifo_irq), 32'h1);
      host.rd(ASTAT, v);
      chk(v, 32'hc6);
      drain();
      chk(32'(fifo_irq), 32'h0);
      host.rd(ADATA, v);
      chk(v, 32'h0);
      host.rd(ASTAT, v);
      chk(v, 32'ha1);
      $display("test watermark done");
      end_sim();
   end
endmodule : adc_sample_fifo_irq_watermark_ctrl_bench
`default_nettype wire
